// >>> src/ssc_pkg.sv
// constants and types of the sync sram cycle control
`default_nettype none
package ssc_pkg;

    localparam int ADDR_W    = 19;   // 512K words
    localparam int LANES     = 4;    // byte lanes of the 36-bit organisation
    localparam int LANE_W    = 9;    // eight data bits plus parity
    localparam int DATA_W    = LANES * LANE_W;
    localparam int BURST_W   = 2;    // four-word burst
    localparam int BUF_DEPTH = 2;

    localparam logic [BURST_W-1:0] CNT_RESET  = 2'h0;
    localparam logic [BURST_W-1:0] CNT_STEP   = 2'h1;
    localparam logic [ADDR_W-1:0]  ADDR_RESET = '0;
    localparam logic [DATA_W-1:0]  DATA_RESET = '0;
    localparam logic [LANES-1:0]   STRB_RESET = '1;

    // kind of transfer that owns the data bus in the next cycle
    typedef enum logic [1:0] {
        XFER_NONE,
        XFER_READ,
        XFER_WRITE
    } ssc_xfer_type;

    // one write beat on its way to the array
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [LANES-1:0]  strb_n;
    } ssc_beat_type;

endpackage
`default_nettype wire

// >>> src/ssc_pair_buffer.sv
// two-entry valid/ready buffer for write beats
`timescale 1ns/1ps
`default_nettype none

module ssc_pair_buffer #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);

    logic [WIDTH-1:0] slot0;
    logic [WIDTH-1:0] slot1;
    logic [1:0]       fill;
    logic             push;
    logic             pop;

    // ready only while a slot is free, so a stalled drain back-pressures
    assign in_ready_o  = (fill != 2'h2);
    assign out_valid_o = (fill != 2'h0);
    assign out_data_o  = slot0;
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // occupancy count
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            fill <= 2'h0;
        else if (push && !pop)
            fill <= fill + 2'h1;
        else if (pop && !push)
            fill <= fill - 2'h1;
    end

    // head slot shifts up on pop; new beat lands in first free place
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            slot0 <= '0;
            slot1 <= '0;
        end
        else
        begin
            if (pop)
                slot0 <= (fill == 2'h2) ? slot1 : in_data_i;
            else if (push && fill == 2'h0)
                slot0 <= in_data_i;
            if (push && ((fill == 2'h1 && !pop) || fill == 2'h2))
                slot1 <= in_data_i;
        end
    end

endmodule

`default_nettype wire

// >>> src/ssc_core.sv
// cycle control and storage of the synchronous burst sram
`timescale 1ns/1ps
`default_nettype none

module ssc_core #(
    parameter int ADDR_W = ssc_pkg::ADDR_W
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic [ADDR_W-1:0]          address_i,
    input  wire logic                       read_not_write_i,
    input  wire logic                       advance_not_load_i,
    input  wire logic                       chip_select_a_n_i,
    input  wire logic                       chip_select_b_i,
    input  wire logic                       chip_select_c_n_i,
    input  wire logic                       clock_gate_n_i,
    input  wire logic [ssc_pkg::LANES-1:0]  byte_write_strobe_n_i,
    input  wire logic                       burst_order_select_i,
    input  wire logic [ssc_pkg::DATA_W-1:0] dq_i,
    output logic      [ssc_pkg::DATA_W-1:0] dq_o,
    output logic                            dq_oe_o
);

    localparam int LANES  = ssc_pkg::LANES;
    localparam int LANE_W = ssc_pkg::LANE_W;
    localparam int BW     = ssc_pkg::BURST_W;
    localparam int DEPTH  = 1 << ADDR_W;

    ssc_pkg::ssc_xfer_type burst;       // direction of the open burst
    ssc_pkg::ssc_xfer_type phase;       // transfer due on the bus now
    ssc_pkg::ssc_xfer_type next_xfer;
    logic [ADDR_W-1:0]     base_addr;
    logic [BW-1:0]         cnt;
    logic [BW-1:0]         next_cnt;
    logic [BW-1:0]         start_low;
    logic [BW-1:0]         low_bits;
    logic [ADDR_W-1:0]     cur_addr;
    logic [ADDR_W-1:0]     phase_addr;
    logic [LANES-1:0]      phase_strb_n;
    logic                  selected;
    logic                  load;
    logic                  active;
    logic                  go;
    logic [ssc_pkg::DATA_W-1:0] rd_word;

    // write beat path through the two-entry buffer
    ssc_pkg::ssc_beat_type push_beat;
    ssc_pkg::ssc_beat_type pop_beat;
    logic                  push_valid;
    logic                  push_ready;
    logic                  pop_valid;
    logic                  pop_ready;
    logic                  pop_fire;

    // all three selects must be true at once
    assign selected = !chip_select_a_n_i && chip_select_b_i
                      && !chip_select_c_n_i;

    // a high clock gate blocks the edge; a full write buffer also stalls
    assign active = !clock_gate_n_i;
    // push and pop share the enabled edges, so ready never drops here
    assign go     = active && push_ready;

    // a load with any false select is a deselect, not a new transfer
    assign load = !advance_not_load_i;

    // decode of the command sampled at this edge
    always_comb
    begin
        next_xfer = ssc_pkg::XFER_NONE;
        if (load)
        begin
            if (selected)
                next_xfer = read_not_write_i ? ssc_pkg::XFER_READ
                                             : ssc_pkg::XFER_WRITE;
            else
                next_xfer = ssc_pkg::XFER_NONE;
        end
        else
        begin
            // direction comes from the load, not from read_not_write
            next_xfer = burst;
        end
    end

    // burst count: zero on a load, wraps past the fourth word
    assign next_cnt  = load ? ssc_pkg::CNT_RESET
                            : cnt + ssc_pkg::CNT_STEP;
    assign start_low = load ? address_i[BW-1:0] : base_addr[BW-1:0];

    // interleaved or linear order of the two low address bits
    assign low_bits = burst_order_select_i
                      ? (start_low ^ next_cnt)
                      : (start_low + next_cnt);

    // upper bits stay put inside a burst; only the low two step
    assign cur_addr = load ? {address_i[ADDR_W-1:BW], low_bits}
                           : {base_addr[ADDR_W-1:BW], low_bits};

    // burst direction; a deselect closes it, pending beat still completes
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            burst <= ssc_pkg::XFER_NONE;
        else if (go)
            burst <= next_xfer;
    end

    // start address, taken only by a selected load
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            base_addr <= ssc_pkg::ADDR_RESET;
        else if (go && load && selected)
            base_addr <= address_i;
    end

    // burst count; frozen while no burst is open, so a no-op
    // advance cannot shift the start of the next burst
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt <= ssc_pkg::CNT_RESET;
        else if (go && (load || burst != ssc_pkg::XFER_NONE))
            cnt <= next_cnt;
    end

    // kind of transfer the bus carries one cycle after the command
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            phase <= ssc_pkg::XFER_NONE;
        else if (go)
            phase <= next_xfer;
    end

    // word address of that transfer
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            phase_addr <= ssc_pkg::ADDR_RESET;
        else if (go)
            phase_addr <= cur_addr;
    end

    // lane enables of that transfer; only a write beat uses them
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            phase_strb_n <= ssc_pkg::STRB_RESET;
        else if (go)
            phase_strb_n <= byte_write_strobe_n_i;
    end

    // write data is taken in the cycle after its command
    assign push_valid       = go && phase == ssc_pkg::XFER_WRITE;
    assign push_beat.addr   = phase_addr;
    assign push_beat.data   = dq_i;
    assign push_beat.strb_n = phase_strb_n;
    // the array drains only on enabled edges, so suspend holds it too
    assign pop_ready        = active;
    assign pop_fire         = pop_valid && pop_ready;

    ssc_pair_buffer #(
        .WIDTH ($bits(ssc_pkg::ssc_beat_type))
    ) u_beat_buf (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (push_valid),
        .in_ready_o  (push_ready),
        .in_data_i   (push_beat),
        .out_valid_o (pop_valid),
        .out_ready_i (pop_ready),
        .out_data_o  (pop_beat)
    );

    // per-lane storage, write enable and read forwarding
    for (genvar l = 0; l < LANES; l++)
    begin : g_lane
        logic [LANE_W-1:0] lane_mem [DEPTH];
        logic [LANE_W-1:0] lane_rd;

        // the array has no reset; a read before any write is unknown
        // each strobe gates only its own lane, any mix at once
        always_ff @(posedge clk_i)
        begin
            if (pop_fire && !pop_beat.strb_n[l])
                lane_mem[pop_beat.addr] <= pop_beat.data[l*LANE_W +: LANE_W];
        end

        // late writes not yet in the array are forwarded, newest wins
        always_comb
        begin
            lane_rd = lane_mem[cur_addr];
            if (pop_valid && pop_beat.addr == cur_addr
                && !pop_beat.strb_n[l])
                lane_rd = pop_beat.data[l*LANE_W +: LANE_W];
            if (push_valid && phase_addr == cur_addr && !phase_strb_n[l])
                lane_rd = dq_i[l*LANE_W +: LANE_W];
        end

        assign rd_word[l*LANE_W +: LANE_W] = lane_rd;
    end

    // bus drive: on only for a read beat, released otherwise
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            dq_oe_o <= 1'b0;
        else if (go)
            dq_oe_o <= (next_xfer == ssc_pkg::XFER_READ);
    end

    // read word is registered at the command edge to be flow-through
    // while released, dq_o keeps its last word; only the enable counts
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            dq_o <= ssc_pkg::DATA_RESET;
        else if (go && next_xfer == ssc_pkg::XFER_READ)
            dq_o <= rd_word;
    end

endmodule

`default_nettype wire

// >>> tb/ssc_props.sv
// checker of the cycle control at the sram pins
`timescale 1ns/1ps
`default_nettype none
module ssc_props (
    input wire logic                       clk_i,
    input wire logic                       rst_n_i,
    input wire logic                       read_not_write_i,
    input wire logic                       advance_not_load_i,
    input wire logic                       chip_select_a_n_i,
    input wire logic                       chip_select_b_i,
    input wire logic                       chip_select_c_n_i,
    input wire logic                       clock_gate_n_i,
    input wire logic [ssc_pkg::DATA_W-1:0] dq_o,
    input wire logic                       dq_oe_o
);
    logic act;
    logic sel;
    // active edge and full three-way select decode
    assign act = !clock_gate_n_i;
    assign sel = !chip_select_a_n_i && chip_select_b_i && !chip_select_c_n_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_rd;
        act && sel && !advance_not_load_i && read_not_write_i;
    endsequence
    sequence s_wr;
        act && sel && !advance_not_load_i && !read_not_write_i;
    endsequence
    sequence s_dsl;
        act && !sel && !advance_not_load_i;
    endsequence
    property p_rd;
        s_rd |=> dq_oe_o;
    endproperty
    property p_wr;
        s_wr |=> !dq_oe_o;
    endproperty
    property p_dsl;
        s_dsl |=> !dq_oe_o;
    endproperty
    property p_end;
        s_rd ##1 s_dsl |-> dq_oe_o ##1 !dq_oe_o;
    endproperty
    property p_adv;
        act && advance_not_load_i && dq_oe_o |=> dq_oe_o;
    endproperty
    property p_nop;
        act && advance_not_load_i && !dq_oe_o |=> !dq_oe_o;
    endproperty
    property p_sus;
        clock_gate_n_i |=> $stable(dq_oe_o) && $stable(dq_o);
    endproperty
    // reset holds the bus released, so no disable here
    property p_pwr;
        disable iff (1'b0) !rst_n_i |-> !dq_oe_o && dq_o == '0;
    endproperty
    a_rd: assert property (p_rd)
        else $error("read load left bus off");
    a_wr: assert property (p_wr)
        else $error("write load drove bus");
    a_dsl: assert property (p_dsl)
        else $error("bus kept after deselect");
    a_end: assert property (p_end)
        else $error("pending read lost");
    a_adv: assert property (p_adv)
        else $error("burst read stopped");
    a_nop: assert property (p_nop)
        else $error("advance drove bus");
    a_sus: assert property (p_sus)
        else $error("suspend changed bus");
    a_pwr: assert property (p_pwr)
        else $error("bus driven in reset");
endmodule
bind ssc_core ssc_props u_props (.clk_i, .rst_n_i, .read_not_write_i,
    .advance_not_load_i, .chip_select_a_n_i, .chip_select_b_i,
    .chip_select_c_n_i, .clock_gate_n_i, .dq_o, .dq_oe_o);
`default_nettype wire

// >>> tb/ssc_host_model.sv
// host controller model driving commands at the sram pins
`timescale 1ns/1ps
`default_nettype none
module ssc_host_model (
    input  wire logic                       clk_i,
    output logic      [ssc_pkg::ADDR_W-1:0] address_i,
    output logic                            read_not_write_i,
    output logic                            advance_not_load_i,
    output logic                            chip_select_a_n_i,
    output logic                            chip_select_b_i,
    output logic                            chip_select_c_n_i,
    output logic                            clock_gate_n_i,
    output logic      [ssc_pkg::LANES-1:0]  byte_write_strobe_n_i,
    output logic      [ssc_pkg::DATA_W-1:0] dq_i
);
    logic [ssc_pkg::DATA_W-1:0] pend;
    logic                       pend_v;
    logic                       wb;
    // idle as a plain no-op until the first command
    initial
    begin
        {address_i, read_not_write_i, pend_v, wb} = '0;
        {advance_not_load_i, chip_select_a_n_i, chip_select_b_i} = 3'h5;
        {chip_select_c_n_i, clock_gate_n_i, dq_i, pend} = '0;
        byte_write_strobe_n_i = 4'hF;
    end
    // one command per edge; write data follows one active cycle later
    task automatic op(
        input logic                       g, adv, rw,
        input logic [2:0]                 cs,
        input logic [ssc_pkg::ADDR_W-1:0] a,
        input logic [ssc_pkg::LANES-1:0]  s,
        input logic [ssc_pkg::DATA_W-1:0] d
    );
        @(posedge clk_i);
        clock_gate_n_i <= g;
        {advance_not_load_i, read_not_write_i} <= {adv, rw};
        {chip_select_a_n_i, chip_select_b_i, chip_select_c_n_i} <= cs;
        address_i <= a;
        byte_write_strobe_n_i <= s;
        // suspend freezes the data pipe; idle data toggles, never stale
        if (!g)
        begin
            dq_i <= pend_v ? pend : ~dq_i;
            pend <= d;
            pend_v <= adv ? wb : (cs == 3'h2 && !rw);
            wb <= adv ? wb : (cs == 3'h2 && !rw);
        end
        #1;
    endtask
endmodule
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench of the sram cycle control
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef logic [ssc_pkg::DATA_W-1:0] ssc_word_type;
    typedef logic [ssc_pkg::ADDR_W-1:0] ssc_addr_type;
    logic         clk_i, rst_n_i, burst_order_select_i, dq_oe_o;
    logic         read_not_write_i, advance_not_load_i, clock_gate_n_i;
    logic         chip_select_a_n_i, chip_select_b_i, chip_select_c_n_i;
    logic [3:0]   byte_write_strobe_n_i;
    ssc_addr_type address_i;
    ssc_word_type dq_i, dq_o;
    int           fail_count = 0, checks = 0, cyc = 0;
    ssc_core dut (.clk_i, .rst_n_i, .address_i, .read_not_write_i,
        .advance_not_load_i, .chip_select_a_n_i, .chip_select_b_i,
        .chip_select_c_n_i, .clock_gate_n_i, .byte_write_strobe_n_i,
        .burst_order_select_i, .dq_i, .dq_o, .dq_oe_o);
    ssc_host_model host (.clk_i, .address_i, .read_not_write_i,
        .advance_not_load_i, .chip_select_a_n_i, .chip_select_b_i,
        .chip_select_c_n_i, .clock_gate_n_i, .byte_write_strobe_n_i, .dq_i);
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // hang guard, far above the hundred or so cycles used
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic chk(input ssc_word_type s, e);
        checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("ERROR at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input ssc_addr_type a, input logic [3:0] s,
                      input ssc_word_type d);
        host.op(1'b0, 1'b0, 1'b0, 3'h2, a, s, d);
    endtask
    task automatic rd(input ssc_addr_type a);
        host.op(1'b0, 1'b0, 1'b1, 3'h2, a, 4'hF, '0);
    endtask
    // advance with write select: must not turn a read burst round
    task automatic ad();
        host.op(1'b0, 1'b1, 1'b0, 3'h2, '0, 4'h0, '0);
    endtask
    task automatic ds(input logic [2:0] c);
        host.op(1'b0, 1'b0, 1'b1, c, ssc_addr_type'(8'h41), 4'hF, '0);
    endtask
    // back-to-back write then read of seven strobe mixes
    task automatic t_lanes();
        logic [3:0]   st [7] = '{4'h0, 4'hE, 4'hD, 4'hB, 4'h7, 4'h5, 4'hF};
        ssc_word_type ex, m, d;
        for (int i = 0; i < 7; i++)
        begin
            d = ssc_word_type'(64'h9E3779B97F4A7C15 >> (i * 5));
            for (int l = 0; l < 4; l++)
                m[9*l+:9] = {9{~st[i][l]}};
            ex = (ex & ~m) | (d & m);
            wr(ssc_addr_type'(8'h20), st[i], d);
            rd(ssc_addr_type'(8'h20));
            ds(3'h0);
            chk(dq_o, ex);
            chk(ssc_word_type'(dq_oe_o), 1);
        end
    endtask
    // burst of six beats to see the wrap, then idle advances
    task automatic t_burst(input logic ord, input logic [1:0] st);
        logic [1:0] lo;
        for (int i = 0; i < 4; i++)
            wr(ssc_addr_type'(8'h40 + i), 4'h0, ssc_word_type'(12'h100 + i));
        ds(3'h0);
        burst_order_select_i <= ord;
        rd(ssc_addr_type'(8'h40 + st));
        for (int j = 0; j < 6; j++)
        begin
            if (j < 5)
                ad();
            else
                ds(3'h0);
            lo = ord ? st ^ 2'(j % 4) : 2'(st + j);
            chk(dq_o, ssc_word_type'(12'h100 + lo));
            chk(ssc_word_type'(dq_oe_o), 1);
        end
        ad();
        chk(ssc_word_type'(dq_oe_o), 0);
        ad();
        chk(ssc_word_type'(dq_oe_o), 0);
    endtask
    // each select false on its own ends a read burst
    task automatic t_desel();
        logic [2:0] cs [3] = '{3'h6, 3'h0, 3'h3};
        for (int i = 0; i < 3; i++)
        begin
            rd(ssc_addr_type'(8'h40));
            ds(cs[i]);
            chk(dq_o, ssc_word_type'(12'h100));
            ad();
            chk(ssc_word_type'(dq_oe_o), 0);
        end
    endtask
    // suspended write load is ignored and the read beat is held
    task automatic t_susp();
        rd(ssc_addr_type'(8'h42));
        for (int i = 0; i < 2; i++)
        begin
            host.op(1'b1, 1'b0, 1'b0, 3'h2, ssc_addr_type'(8'h43), 4'h0, '1);
            chk(dq_o, ssc_word_type'(12'h102));
            chk(ssc_word_type'(dq_oe_o), 1);
        end
        rd(ssc_addr_type'(8'h43));
        ds(3'h0);
        chk(dq_o, ssc_word_type'(12'h103));
    endtask
    // write burst with read select on its advances, then read it back
    task automatic t_wburst();
        for (int i = 0; i < 4; i++)
        begin
            host.op(1'b0, i != 0, i != 0, 3'h2, ssc_addr_type'(8'h62), 4'h0,
                    ssc_word_type'(12'h200 + i));
            chk(ssc_word_type'(dq_oe_o), 0);
        end
        rd(ssc_addr_type'(8'h62));
        for (int j = 0; j < 4; j++)
        begin
            if (j < 3)
                ad();
            else
                ds(3'h0);
            chk(dq_o, ssc_word_type'(12'h200 + j));
        end
    endtask
    initial
    begin
        // start high so the drop below is a clean reset edge
        rst_n_i = 1'b1;
        burst_order_select_i = 1'b0;
        #1 rst_n_i = 1'b0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i) #1;
        chk(ssc_word_type'(dq_oe_o), 0);
        t_lanes();
        t_burst(1'b1, 2'h1);
        t_burst(1'b1, 2'h2);
        t_burst(1'b0, 2'h1);
        t_burst(1'b0, 2'h3);
        t_desel();
        t_susp();
        t_wburst();
        give_verdict();
    end
endmodule
`default_nettype wire
